/* File: hw/flag_wake_map.svh */
// timing values, cycle counts and edge/symbol limits for the flag and wake supervision block
`ifndef FLAG_WAKE_MAP_SVH
`define FLAG_WAKE_MAP_SVH
`define CLK_PERIOD_NS      20
`define WAKE_LOW_NS        1000
`define WAKE_IDLE_NS       1000
`define BSS_GAP_NS         130
`define TRANSMIT_ENABLE_N_CLAMP_NS      1000
`define BGE_CLAMP_NS       1000
`define UV_DET_NS          100
`define UV_REC_NS          100
`define WAKE_LOW_CYC       ((`WAKE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_IDLE_CYC      ((`WAKE_IDLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BSS_GAP_CYC        ((`BSS_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TRANSMIT_ENABLE_N_CLAMP_CYC     ((`TRANSMIT_ENABLE_N_CLAMP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BGE_CLAMP_CYC      ((`BGE_CLAMP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define UV_DET_CYC         ((`UV_DET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define UV_REC_CYC         ((`UV_REC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SERIAL_EDGES       16
`define WAKE_SYMBOLS       2
`endif

/* File: hw/flag_wake_pkg.sv */
// types shared by the flag and wake supervision block
package flag_wake_pkg;
  typedef logic [7:0] count_t;
  typedef enum logic [1:0] {
    WK_WAIT_LOW  = 2'b00,
    WK_LOW       = 2'b01,
    WK_HIGH      = 2'b10
  } wake_state_e;
endpackage : flag_wake_pkg

/* File: hw/flag_wake_logic.sv */
// flag keeping, wake detection and clamp supervision of a bus transceiver node
// How it works
// - wake needs two back-to-back wake symbols
// - symbol is long low then long idle
// - long recessive high may replace idle
// - short byte-start gaps inside phases tolerated
// - invalid pattern leaves wake flag alone
// - shorts detected only while transmitting
// - no bus error during wake or CAS
// - clamped transmit enable sets flag, disables transmitter
// - clamped guardian enable only sets flag
// - eleven flags: five status, six error
// - wake flag set standby, drives receive low
// - normal flag follows normal mode
// - transmitter flag follows transmitter enable
// - guardian clamp flag clears when input low
// - power-on flag set at reset, cleared normal
// - bus error flag, cleared when the fault ends or by enable edge
// - overtemperature flag cleared by high enable
// - enable clamp flag clears on enable high
// - filtered supply undervoltage flags force standby
// - serial error cleared by select falling edge
// - four flags change only in normal mode
// - transmitter enable needs guardian, normal, no overtemperature or enable clamp
// - serial error unless exactly sixteen clock edges
// - reset clears all flags but power-on and both undervoltage flags
`include "flag_wake_map.svh"
module flag_wake_logic (
  // clock and reset
  input  wire logic I_CLK,
  input  wire logic I_RESET,
  // host control pins
  input  wire logic I_TRANSMIT_ENABLE_N,
  input  wire logic I_BUS_GUARDIAN_ENABLE,
  input  wire logic I_STANDBY_SELECT_N,
  input  wire logic I_SERIAL_SELECT_N,
  input  wire logic I_SERIAL_CLK,
  // analog section reports
  input  wire logic I_BUS_LOW,
  input  wire logic I_BUS_HIGH,
  input  wire logic I_BUS_FAULT,
  input  wire logic I_SPECIAL_SYMBOL,
  input  wire logic I_OVER_TEMP,
  input  wire logic I_CORE_SUPPLY_LOW,
  input  wire logic I_IO_SUPPLY_LOW,
  // flags
  output logic      O_BUS_WAKE,
  output logic      O_NORMAL_MODE,
  output logic      O_TX_ENABLED,
  output logic      O_GUARDIAN_CLAMPED,
  output logic      O_POWER_ON_FLAG,
  output logic      O_BUS_ERROR,
  output logic      O_OVER_TEMP,
  output logic      O_TX_EN_CLAMPED,
  output logic      O_CORE_UNDERVOLTAGE_FLAG,
  output logic      O_IO_UNDERVOLTAGE_FLAG,
  output logic      O_SERIAL_ERROR,
  // pins driven toward host
  output logic      O_RECEIVE_N,
  output logic      O_ERROR_INDICATOR_N,
  output logic      O_SERIAL_DATA_OUT_OE
);
  import flag_wake_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // saturating counter step, restarts when the condition drops
  function automatic count_t count_step(input logic cond, input count_t cnt);
    if (!cond) begin
      count_step = 8'h00;
    end else if (cnt == 8'hff) begin
      count_step = cnt;
    end else begin
      count_step = cnt + 8'h01;
    end
  endfunction : count_step

  logic wake_flag, normal_flag, tx_flag, bge_clamp, power_on_flag, bus_err, temp;
  logic transmit_enable_n_clamp, uv_core, uv_io, ser_err;
  logic transmit_enable_n_prev, serial_select_n_prev, sclk_prev;
  count_t transmit_enable_n_cnt, bge_cnt, uvc_cnt, uvc_rec, uvi_cnt, uvi_rec;
  count_t ph_cnt, gap_cnt;
  count_t edge_cnt;
  wake_state_e wk_state;
  logic [1:0] sym_cnt;
  logic wake_event;
  logic enter_normal, leave_normal, in_normal, next_tx;

  // normal when selected and no supply fault; leaving on either
  assign in_normal    = I_STANDBY_SELECT_N && !uv_core && !uv_io;
  assign enter_normal = in_normal && !normal_flag;
  assign leave_normal = !in_normal && normal_flag;
  // transmitter only with guardian, normal and no disabling fault
  assign next_tx = I_BUS_GUARDIAN_ENABLE && normal_flag && !temp && !transmit_enable_n_clamp;

  // ----------------------------------------
  // edge history
  // ----------------------------------------
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      transmit_enable_n_prev <= 1'b1;
      serial_select_n_prev <= 1'b1;
      sclk_prev <= 1'b0;
    end else begin
      transmit_enable_n_prev <= I_TRANSMIT_ENABLE_N;
      serial_select_n_prev <= I_SERIAL_SELECT_N;
      sclk_prev <= I_SERIAL_CLK;
    end
  end

  // ----------------------------------------
  // wake detector
  // ----------------------------------------
  // a gap shorter than the byte-start length does not restart a phase
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      wk_state <= WK_WAIT_LOW;
      ph_cnt   <= 8'h00;
      gap_cnt  <= 8'h00;
      sym_cnt  <= 2'b00;
    end else if (normal_flag) begin
      // low-power receiver is off in normal mode; a stale count must not re-wake
      wk_state <= WK_WAIT_LOW;
      sym_cnt  <= 2'b00;
    end else begin
      case (wk_state)
        WK_WAIT_LOW: begin
          ph_cnt  <= 8'h00;
          gap_cnt <= 8'h00;
          if (I_BUS_LOW) begin
            wk_state <= WK_LOW;
          end
        end
        WK_LOW: begin
          gap_cnt <= count_step(!I_BUS_LOW, gap_cnt);
          if (I_BUS_LOW) begin
            ph_cnt <= count_step(1'b1, ph_cnt);
          end
          if (!I_BUS_LOW && ph_cnt >= 8'(`WAKE_LOW_CYC)) begin
            wk_state <= WK_HIGH;
            ph_cnt   <= 8'h00;
            gap_cnt  <= 8'h00;
          end else if (!I_BUS_LOW && gap_cnt >= 8'(`BSS_GAP_CYC)) begin
            wk_state <= WK_WAIT_LOW;
            sym_cnt  <= 2'b00;
          end
        end
        WK_HIGH: begin
          // idle and recessive high count alike
          gap_cnt <= count_step(I_BUS_LOW, gap_cnt);
          if (!I_BUS_LOW) begin
            ph_cnt <= count_step(1'b1, ph_cnt);
          end
          if (ph_cnt >= 8'(`WAKE_IDLE_CYC) && I_BUS_LOW) begin
            wk_state <= WK_LOW;
            ph_cnt   <= 8'h00;
            gap_cnt  <= 8'h00;
            sym_cnt  <= (sym_cnt == 2'b11) ? sym_cnt : sym_cnt + 2'b01;
          end else if (I_BUS_LOW && gap_cnt >= 8'(`BSS_GAP_CYC)) begin
            wk_state <= WK_WAIT_LOW;
            sym_cnt  <= 2'b00;
          end else if (ph_cnt >= 8'(`WAKE_IDLE_CYC) && sym_cnt == 2'b01) begin
            sym_cnt  <= 2'b10; // second symbol complete on long idle
          end
        end
        default: begin
          wk_state <= WK_WAIT_LOW;
        end
      endcase
    end
  end
  assign wake_event = (sym_cnt >= 2'(`WAKE_SYMBOLS));

  // ----------------------------------------
  // clamp and undervoltage qualifiers
  // ----------------------------------------
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      transmit_enable_n_cnt <= 8'h00;
      bge_cnt  <= 8'h00;
      uvc_cnt  <= 8'h00;
      uvc_rec  <= 8'h00;
      uvi_cnt  <= 8'h00;
      uvi_rec  <= 8'h00;
    end else begin
      transmit_enable_n_cnt <= count_step(!I_TRANSMIT_ENABLE_N && normal_flag, transmit_enable_n_cnt);
      bge_cnt  <= count_step(I_BUS_GUARDIAN_ENABLE && normal_flag, bge_cnt);
      uvc_cnt  <= count_step(I_CORE_SUPPLY_LOW, uvc_cnt);
      uvc_rec  <= count_step(!I_CORE_SUPPLY_LOW, uvc_rec);
      uvi_cnt  <= count_step(I_IO_SUPPLY_LOW, uvi_cnt);
      uvi_rec  <= count_step(!I_IO_SUPPLY_LOW, uvi_rec);
    end
  end

  // ----------------------------------------
  // mode and status flags
  // ----------------------------------------
  // power-on flag comes up set after reset; undervoltage flags start set
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      normal_flag <= 1'b0;
      tx_flag     <= 1'b0;
      power_on_flag        <= 1'b1;
      wake_flag   <= 1'b0;
      uv_core     <= 1'b1;
      uv_io       <= 1'b1;
    end else begin
      normal_flag <= in_normal;
      tx_flag     <= next_tx;
      if (enter_normal) begin
        power_on_flag <= 1'b0;
      end
      // wake only in standby and with a healthy core supply
      if (wake_event && !in_normal && !normal_flag && !uv_core) begin
        wake_flag <= 1'b1;
      end else if (enter_normal) begin
        wake_flag <= 1'b0;
      end
      if (uvc_cnt >= 8'(`UV_DET_CYC)) begin
        uv_core <= 1'b1;
      end else if (uvc_rec >= 8'(`UV_REC_CYC)) begin
        uv_core <= 1'b0;
      end
      if (uvi_cnt >= 8'(`UV_DET_CYC)) begin
        uv_io <= 1'b1;
      end else if (uvi_rec >= 8'(`UV_REC_CYC)) begin
        uv_io <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // normal-mode guardian clamp and error flags
  // ----------------------------------------
  // only touched in normal mode or on the cycle it is left
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      bge_clamp  <= 1'b0;
      bus_err    <= 1'b0;
      temp       <= 1'b0;
      transmit_enable_n_clamp <= 1'b0;
    end else if (normal_flag) begin
      if (bge_cnt >= 8'(`BGE_CLAMP_CYC)) begin
        bge_clamp <= 1'b1;
      end else if (!I_BUS_GUARDIAN_ENABLE) begin
        bge_clamp <= 1'b0;
      end
      if (I_BUS_FAULT && tx_flag && !I_SPECIAL_SYMBOL) begin
        bus_err <= 1'b1;
      end else if (!I_BUS_FAULT || (I_TRANSMIT_ENABLE_N && !transmit_enable_n_prev)) begin
        bus_err <= 1'b0;
      end
      if (I_OVER_TEMP) begin
        temp <= 1'b1;
      end else if (I_TRANSMIT_ENABLE_N) begin
        temp <= 1'b0;
      end
      if (transmit_enable_n_cnt >= 8'(`TRANSMIT_ENABLE_N_CLAMP_CYC)) begin
        transmit_enable_n_clamp <= 1'b1;
      end else if (I_TRANSMIT_ENABLE_N) begin
        transmit_enable_n_clamp <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // serial frame check
  // ----------------------------------------
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      edge_cnt <= 8'h00;
      ser_err  <= 1'b0;
    end else begin
      if (!I_SERIAL_SELECT_N && sclk_prev && !I_SERIAL_CLK) begin
        edge_cnt <= count_step(1'b1, edge_cnt);
      end
      // error set wins over the falling-select clear
      if ((!I_SERIAL_SELECT_N && sclk_prev && !I_SERIAL_CLK
           && edge_cnt >= 8'(`SERIAL_EDGES))
          || (I_SERIAL_SELECT_N && !serial_select_n_prev && edge_cnt != 8'(`SERIAL_EDGES))) begin
        ser_err <= 1'b1;
      end else if (!I_SERIAL_SELECT_N && serial_select_n_prev) begin
        ser_err  <= 1'b0;
      end
      if (!I_SERIAL_SELECT_N && serial_select_n_prev) begin
        edge_cnt <= 8'h00;
      end
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      O_RECEIVE_N          <= 1'b1;
      O_ERROR_INDICATOR_N  <= 1'b1;
      O_SERIAL_DATA_OUT_OE <= 1'b0;
    end else begin
      O_RECEIVE_N <= !wake_flag;
      O_ERROR_INDICATOR_N <= !((wake_flag && !I_STANDBY_SELECT_N)
                              || bus_err || temp || transmit_enable_n_clamp
                              || uv_core || uv_io || ser_err);
      O_SERIAL_DATA_OUT_OE <= !I_SERIAL_SELECT_N && !ser_err && !uv_io;
    end
  end
  // eleven flag outputs mirror internal flops one cycle later
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      {O_BUS_WAKE, O_NORMAL_MODE, O_TX_ENABLED, O_GUARDIAN_CLAMPED} <= 4'h0;
      O_POWER_ON_FLAG <= 1'b1;
      {O_BUS_ERROR, O_OVER_TEMP, O_TX_EN_CLAMPED} <= 3'h0;
      {O_CORE_UNDERVOLTAGE_FLAG, O_IO_UNDERVOLTAGE_FLAG} <= 2'h3;
      O_SERIAL_ERROR <= 1'b0;
    end else begin
      {O_BUS_WAKE, O_NORMAL_MODE, O_TX_ENABLED, O_GUARDIAN_CLAMPED}
        <= {wake_flag, normal_flag, tx_flag, bge_clamp};
      O_POWER_ON_FLAG <= power_on_flag;
      {O_BUS_ERROR, O_OVER_TEMP, O_TX_EN_CLAMPED} <= {bus_err, temp, transmit_enable_n_clamp};
      {O_CORE_UNDERVOLTAGE_FLAG, O_IO_UNDERVOLTAGE_FLAG} <= {uv_core, uv_io};
      O_SERIAL_ERROR <= ser_err;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);

  tx_gate_a: assert property (tx_flag |-> $past(I_BUS_GUARDIAN_ENABLE) && !$past(temp))
    else $error("transmitter enabled without guardian or with overtemp");
  transmit_enable_n_clamp_set_a: assert property (normal_flag && transmit_enable_n_cnt >= 8'(`TRANSMIT_ENABLE_N_CLAMP_CYC)
    |=> transmit_enable_n_clamp)
    else $error("transmit enable clamp not flagged");
  clamp_disable_a: assert property (transmit_enable_n_clamp |=> !tx_flag)
    else $error("transmitter stays on with clamped enable");
  wake_standby_a: assert property ($rose(wake_flag) |-> !$past(normal_flag))
    else $error("wake flag set outside standby");
  wake_clear_a: assert property (enter_normal |=> !wake_flag && !power_on_flag)
    else $error("wake or power-on flag not cleared in normal");
  rx_low_a: assert property (wake_flag |=> !O_RECEIVE_N)
    else $error("receive output not low while wake set");
  err_pin_a: assert property (bus_err || temp || uv_core |=> !O_ERROR_INDICATOR_N)
    else $error("error output not low with error flag");
  quiet_flags_a: assert property (!normal_flag |=> $stable(bus_err) && $stable(temp))
    else $error("normal-only flag changed in standby");
  ser_err_a: assert property ($rose(I_SERIAL_SELECT_N) && edge_cnt != 8'(`SERIAL_EDGES)
    |=> ser_err)
    else $error("bad serial frame not flagged");
  uv_standby_a: assert property (uv_core |=> !normal_flag)
    else $error("normal mode kept during undervoltage");

  wake_seen_c: cover property ($rose(wake_flag));
  clamp_seen_c: cover property ($rose(transmit_enable_n_clamp));
  ser_err_seen_c: cover property ($rose(ser_err));
  bus_err_seen_c: cover property ($rose(bus_err));
  leave_seen_c: cover property (leave_normal);
endmodule : flag_wake_logic

/* File: tb/bus_host_model.sv */
// host and bus node model: serial readout frames and wake-up symbols
module bus_host_model (
  // clock
  input  wire logic       i_clk,
  // requests from the bench
  input  wire logic       i_frame_go,
  input  wire logic [4:0] i_frame_edges,
  input  wire logic       i_sym_go,
  input  wire logic       i_gap,
  // pins toward the device, busy status toward the bench
  output logic            o_select_n,
  output logic            o_sclk,
  output logic            o_bus_low,
  output logic            o_bus_high,
  output logic            o_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] togg;
  logic [1:0] div;
  logic [6:0] ph;
  // ----------------------------------------
  // serial host
  // ----------------------------------------
  initial begin
    o_select_n = 1'b1;
    o_sclk = 1'b0;
    togg = 6'h00;
    div = 2'h0;
    ph = 7'h00;
  end
  // clock idles low and stands still outside frames; four cycles per toggle
  always @(posedge i_clk) begin
    div <= div + 2'h1;
    if (i_frame_go) begin
      o_select_n <= 1'b0;
      togg <= {i_frame_edges, 1'b0};
      div <= 2'h0;
    end else if (!o_select_n && div == 2'h3) begin
      if (togg == 6'h00) o_select_n <= 1'b1;
      else begin
        o_sclk <= ~o_sclk;
        togg <= togg - 6'h01;
      end
    end
  end
  // ----------------------------------------
  // bus node
  // ----------------------------------------
  // plain symbol: 64 low, 63 recessive high; gaps mimic byte starts at top rate
  always @(posedge i_clk) begin
    if (i_sym_go) ph <= 7'h7f;
    else if (ph != 7'h00) ph <= ph - 7'h01;
  end
  // gaps of six cycles stay under the tolerated interruption
  assign o_bus_low  = ph[6] && !(i_gap && ph[4:0] >= 5'h10 && ph[4:0] < 5'h16);
  assign o_bus_high = (ph != 7'h00) && !o_bus_low;
  assign o_busy     = !o_select_n || (ph != 7'h00);
endmodule : bus_host_model

/* File: tb/tb.sv */
// self-checking bench for the flag and wake supervision block
`include "flag_wake_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, transmit_enable_n_n, bus_guardian_enable, stby_n, fault, special, temp, core_low, io_low;
  logic frame_go, sym_go, gap, sel_n, sclk, bus_low, bus_high, busy;
  logic [4:0] edges;
  logic wake, normal, tx_en, g_clamp, power_on_flag, bus_err, over_t, tx_clamp;
  logic core_uv, io_uv, ser_err, rx_n, err_n, sdo_oe;
  int n_mismatch = 0;
  int samples_checked = 0;
  // ----------------------------------------
  // instances
  // ----------------------------------------
  flag_wake_logic flag_wake_logic_inst (
    .I_CLK(clk), .I_RESET(rst), .I_TRANSMIT_ENABLE_N(transmit_enable_n_n),
    .I_BUS_GUARDIAN_ENABLE(bus_guardian_enable), .I_STANDBY_SELECT_N(stby_n),
    .I_SERIAL_SELECT_N(sel_n), .I_SERIAL_CLK(sclk), .I_BUS_LOW(bus_low),
    .I_BUS_HIGH(bus_high), .I_BUS_FAULT(fault), .I_SPECIAL_SYMBOL(special),
    .I_OVER_TEMP(temp), .I_CORE_SUPPLY_LOW(core_low), .I_IO_SUPPLY_LOW(io_low),
    .O_BUS_WAKE(wake), .O_NORMAL_MODE(normal), .O_TX_ENABLED(tx_en),
    .O_GUARDIAN_CLAMPED(g_clamp), .O_POWER_ON_FLAG(power_on_flag), .O_BUS_ERROR(bus_err),
    .O_OVER_TEMP(over_t), .O_TX_EN_CLAMPED(tx_clamp),
    .O_CORE_UNDERVOLTAGE_FLAG(core_uv), .O_IO_UNDERVOLTAGE_FLAG(io_uv),
    .O_SERIAL_ERROR(ser_err), .O_RECEIVE_N(rx_n), .O_ERROR_INDICATOR_N(err_n),
    .O_SERIAL_DATA_OUT_OE(sdo_oe));
  bus_host_model bus_host_model_inst (
    .i_clk(clk), .i_frame_go(frame_go), .i_frame_edges(edges), .i_sym_go(sym_go),
    .i_gap(gap), .o_select_n(sel_n), .o_sclk(sclk), .o_bus_low(bus_low),
    .o_bus_high(bus_high), .o_busy(busy));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  // clock, 50 MHz
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task automatic ck(input string name, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      $display("unexpected %s expected %b seen %b", name, exp, got);
      n_mismatch++;
    end
  endtask : ck
  // settle one ns past the edge so registered outputs have landed
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  // bounded wait for the model to finish a frame or symbol
  task automatic wait_idle();
    int k;
    k = 0;
    @(posedge clk);
    while (busy && k < 400) begin
      @(posedge clk);
      k++;
    end
    if (busy) begin
      n_mismatch++;
      finish_test();
    end
    #1;
  endtask : wait_idle
  task automatic send(input logic g);
    gap <= g;
    sym_go <= 1'b1;
    @(posedge clk);
    sym_go <= 1'b0;
    wait_idle();
  endtask : send
  task automatic frame(input logic [4:0] n);
    edges <= n;
    frame_go <= 1'b1;
    @(posedge clk);
    frame_go <= 1'b0;
    wait_idle();
    wt(4);
  endtask : frame
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    wt(1);
    ck("power_on_flag", 1'b1, power_on_flag);
    ck("wake", 1'b0, wake);
    ck("bus_err", 1'b0, bus_err);
    ck("ser_err", 1'b0, ser_err);
    wt(`UV_REC_CYC + 5);
    ck("core_uv", 1'b0, core_uv);
    ck("io_uv", 1'b0, io_uv);
  endtask : t_reset
  // two gapped symbols in standby; one alone must not wake
  task automatic t_wake();
    send(1'b1);
    wt(2);
    ck("wake", 1'b0, wake);
    send(1'b1);
    wt(4);
    ck("wake", 1'b1, wake);
    ck("rx_n", 1'b0, rx_n);
    ck("err_n", 1'b0, err_n);
    stby_n <= 1'b1;
    wt(4);
    ck("normal", 1'b1, normal);
    ck("wake", 1'b0, wake);
    ck("power_on_flag", 1'b0, power_on_flag);
    ck("rx_n", 1'b1, rx_n);
  endtask : t_wake
  task automatic t_bus_err();
    bus_guardian_enable <= 1'b1;
    transmit_enable_n_n <= 1'b0;
    wt(4);
    ck("tx_en", 1'b1, tx_en);
    fault <= 1'b1;
    special <= 1'b1;
    wt(4);
    ck("bus_err", 1'b0, bus_err);
    special <= 1'b0;
    wt(4);
    ck("bus_err", 1'b1, bus_err);
    ck("err_n", 1'b0, err_n);
    fault <= 1'b0;
    wt(4);
    ck("bus_err", 1'b0, bus_err);
    transmit_enable_n_n <= 1'b1;
    bus_guardian_enable <= 1'b0;
    wt(4);
    ck("tx_en", 1'b0, tx_en);
  endtask : t_bus_err
  task automatic t_clamp();
    bus_guardian_enable <= 1'b1;
    transmit_enable_n_n <= 1'b0;
    wt(`TRANSMIT_ENABLE_N_CLAMP_CYC + 8);
    ck("tx_clamp", 1'b1, tx_clamp);
    ck("tx_en", 1'b0, tx_en);
    ck("err_n", 1'b0, err_n);
    ck("g_clamp", 1'b1, g_clamp);
    ck("normal", 1'b1, normal);
    transmit_enable_n_n <= 1'b1;
    bus_guardian_enable <= 1'b0;
    wt(4);
    ck("tx_clamp", 1'b0, tx_clamp);
    ck("g_clamp", 1'b0, g_clamp);
  endtask : t_clamp
  // temperature flag holds while enable stays low
  task automatic t_temp();
    bus_guardian_enable <= 1'b1;
    temp <= 1'b1;
    transmit_enable_n_n <= 1'b0;
    wt(4);
    ck("over_t", 1'b1, over_t);
    ck("tx_en", 1'b0, tx_en);
    ck("err_n", 1'b0, err_n);
    temp <= 1'b0;
    wt(4);
    ck("over_t", 1'b1, over_t);
    transmit_enable_n_n <= 1'b1;
    bus_guardian_enable <= 1'b0;
    wt(4);
    ck("over_t", 1'b0, over_t);
  endtask : t_temp
  task automatic t_serial();
    frame(5'h10);
    ck("ser_err", 1'b0, ser_err);
    frame(5'h0f);
    ck("ser_err", 1'b1, ser_err);
    ck("err_n", 1'b0, err_n);
    edges <= 5'h10;
    frame_go <= 1'b1;
    wt(1);
    frame_go <= 1'b0;
    wt(4);
    ck("ser_err", 1'b0, ser_err);
    ck("sdo_oe", 1'b1, sdo_oe);
    wait_idle();
    frame(5'h11);
    ck("ser_err", 1'b1, ser_err);
    ck("sdo_oe", 1'b0, sdo_oe);
    frame(5'h10);
    ck("ser_err", 1'b0, ser_err);
  endtask : t_serial
  task automatic t_uv();
    core_low <= 1'b1;
    wt(`UV_DET_CYC + 5);
    ck("core_uv", 1'b1, core_uv);
    ck("normal", 1'b0, normal);
    core_low <= 1'b0;
    wt(`UV_REC_CYC + 5);
    ck("core_uv", 1'b0, core_uv);
    ck("err_n", 1'b1, err_n);
    io_low <= 1'b1;
    wt(`UV_DET_CYC + 5);
    ck("io_uv", 1'b1, io_uv);
    ck("err_n", 1'b0, err_n);
    io_low <= 1'b0;
    wt(`UV_REC_CYC + 5);
    ck("normal", 1'b1, normal);
  endtask : t_uv
  // clamp timing must not run outside normal mode
  task automatic t_freeze();
    stby_n <= 1'b0;
    transmit_enable_n_n <= 1'b0;
    wt(`TRANSMIT_ENABLE_N_CLAMP_CYC + 8);
    ck("tx_clamp", 1'b0, tx_clamp);
    transmit_enable_n_n <= 1'b1;
  endtask : t_freeze
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    transmit_enable_n_n = 1'b1;
    bus_guardian_enable = 1'b0;
    stby_n = 1'b0;
    fault = 1'b0;
    special = 1'b0;
    temp = 1'b0;
    core_low = 1'b0;
    io_low = 1'b0;
    frame_go = 1'b0;
    sym_go = 1'b0;
    gap = 1'b0;
    edges = 5'h00;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_wake();
    t_bus_err();
    t_clamp();
    t_temp();
    t_serial();
    t_uv();
    t_freeze();
    finish_test();
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
endmodule : tb
